// *** drive_word_pkg_status.sv ***
`timescale 1ns/10ps
`default_nettype none
package drive_word_pkg;
  // Parameter codes: menu times one hundred plus parameter number
  localparam logic [13:0] CODE_CMD_WORD = 14'd9011;
  localparam logic [13:0] CODE_STATE_WORD = 14'd1040;
  localparam logic [13:0] DC_MAP_LIMIT = 14'd1999;
  // Command word field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_SEQ0 = 1;
  localparam int BIT_SEQ1 = 2;
  localparam int BIT_SEQ2 = 3;
  localparam int BIT_TRIP = 4;
  localparam int BIT_PRESET0 = 5;
  localparam int BIT_PRESET1 = 6;
  localparam int BIT_APP0 = 7;
  localparam int BIT_APP1 = 8;
  localparam int BIT_MASK0 = 9;
  localparam int BIT_MASK1 = 10;
  localparam int BIT_MASK2 = 11;
  localparam int BIT_MASK3 = 12;
  localparam int BIT_APP2 = 13;
  localparam int BIT_MASK5 = 14;
  localparam int BIT_MASK6 = 15;
  // Sequencer mode selector values
  localparam logic [2:0] MODE_LOGIC_SEQ = 3'h3;
  localparam logic [2:0] MODE_WIRE_PROOF = 3'h4;
  // Reset values and the default external trip code
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [13:0] MAP_RESET = 14'h0000;
  localparam logic [7:0] EXT_TRIP_CODE_DEFAULT = 8'h34;
  // Shown drive state
  typedef enum logic [1:0] {
    SHOW_INHIBIT,
    SHOW_STOPPED,
    SHOW_FORWARD,
    SHOW_REVERSE
  } show_type;
endpackage : drive_word_pkg

// Assembles both forms of the status word one cycle after its inputs
module state_word_builder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Drive condition bits, healthy at bit 0 up to mains loss at bit 14
  input wire logic [14:0] cond_bits,
  // Indicator status and present trip code for the DC variant
  input wire logic [7:0] led_status,
  input wire logic [7:0] trip_code,
  // Assembled words
  output logic [15:0] state_word,
  output logic [15:0] dc_state_word
);
  import drive_word_pkg::*;

  logic [15:0] state_word_r, state_word_nxt;
  logic [15:0] dc_state_word_r, dc_state_word_nxt;

  // ----------------------------------------
  // Word assembly
  // ----------------------------------------
  // Bit 15 of state_word is unused and reads zero; in dc_state_word it is trip_code bit 7
  always_comb begin
    state_word_nxt = {1'b0, cond_bits};
    dc_state_word_nxt = {trip_code, led_status};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_word_r <= CMD_RESET;
      dc_state_word_r <= CMD_RESET;
    end else begin
      state_word_r <= state_word_nxt;
      dc_state_word_r <= dc_state_word_nxt;
    end
  end

  assign state_word = state_word_r;
  assign dc_state_word = dc_state_word_r;
endmodule // state_word_builder
`default_nettype wire

// *** drive_control_status_words.sv ***
`timescale 1ns/10ps
`default_nettype none
module drive_control_status_words #(
  parameter int NUM_SLOTS = 4,
  parameter bit DC_VARIANT = 1'b0,
  parameter logic [7:0] EXT_TRIP_CODE = drive_word_pkg::EXT_TRIP_CODE_DEFAULT // Value arbitrary
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Parameter access port from the network side
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [13:0] acc_code,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  output logic acc_ack,
  output logic acc_err,
  // Output slot mapping writes
  input wire logic map_wr,
  input wire logic [$clog2(NUM_SLOTS)-1:0] map_slot,
  input wire logic [13:0] map_value,
  output logic map_reject,
  output logic [16*NUM_SLOTS-1:0] slot_words,
  // Drive-side inputs
  input wire logic [2:0] seq_mode,
  input wire logic [14:0] cond_bits,
  input wire logic [7:0] led_status,
  input wire logic [7:0] trip_code,
  // Sequencer parameters
  output logic drive_enable,
  output logic [2:0] seq_bits,
  output logic [1:0] preset_sel,
  output logic [2:0] app_bits,
  output logic run_fwd,
  output logic run_rev,
  output logic jog,
  output logic [1:0] shown_state,
  output logic ext_trip,
  output logic [7:0] ext_trip_code
);
  import drive_word_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Mask gate: a set mask passes the command bit, a clear one holds
  function automatic logic gated(input logic mask, input logic cmd, input logic held);
    gated = mask ? cmd : held;
  endfunction

  // Mapping values the variant accepts
  function automatic logic map_ok(input logic [13:0] v);
    map_ok = !(DC_VARIANT && (v > DC_MAP_LIMIT));
  endfunction

  // ----------------------------------------
  // Status word source
  // ----------------------------------------
  logic [15:0] state_word;
  logic [15:0] dc_state_word;

  state_word_builder u_state (
    .clk(clk),
    .rst_n(rst_n),
    .cond_bits(cond_bits),
    .led_status(led_status),
    .trip_code(trip_code),
    .state_word(state_word),
    .dc_state_word(dc_state_word)
  );

  // ----------------------------------------
  // Command word state
  // ----------------------------------------
  logic enable_r, enable_nxt;
  logic [2:0] seq_r, seq_nxt;
  logic [1:0] preset_r, preset_nxt;
  logic [2:0] app_r, app_nxt;
  logic trip_r, trip_nxt;
  logic [7:0] code_r, code_nxt;
  logic cmd_write;

  assign cmd_write = acc_wr && (acc_code == CODE_CMD_WORD);

  // Only a write to the command word code moves the targets
  always_comb begin
    enable_nxt = enable_r;
    seq_nxt = seq_r;
    preset_nxt = preset_r;
    app_nxt = app_r;
    trip_nxt = 1'b0;
    if (cmd_write) begin
      enable_nxt = gated(acc_wdata[BIT_MASK0], acc_wdata[BIT_ENABLE], enable_r);
      seq_nxt[0] = gated(acc_wdata[BIT_MASK1], acc_wdata[BIT_SEQ0], seq_r[0]);
      seq_nxt[1] = gated(acc_wdata[BIT_MASK2], acc_wdata[BIT_SEQ1], seq_r[1]);
      seq_nxt[2] = gated(acc_wdata[BIT_MASK3], acc_wdata[BIT_SEQ2], seq_r[2]);
      preset_nxt[0] = gated(acc_wdata[BIT_MASK5], acc_wdata[BIT_PRESET0], preset_r[0]);
      preset_nxt[1] = gated(acc_wdata[BIT_MASK6], acc_wdata[BIT_PRESET1], preset_r[1]);
      app_nxt = {acc_wdata[BIT_APP2], acc_wdata[BIT_APP1], acc_wdata[BIT_APP0]};
      trip_nxt = acc_wdata[BIT_TRIP];
    end
    // Code is registered beside the pulse so the pin comes from a flip-flop
    code_nxt = trip_nxt ? EXT_TRIP_CODE : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 1'b0;
      seq_r <= 3'h0;
      preset_r <= 2'h0;
      app_r <= 3'h0;
      trip_r <= 1'b0;
      code_r <= 8'h00;
    end else begin
      enable_r <= enable_nxt;
      seq_r <= seq_nxt;
      preset_r <= preset_nxt;
      app_r <= app_nxt;
      trip_r <= trip_nxt;
      code_r <= code_nxt;
    end
  end

  // ----------------------------------------
  // Sequencing decode
  // ----------------------------------------
  // Decoded from the next values so outputs track the word with no extra lag
  logic fwd_r, fwd_nxt;
  logic rev_r, rev_nxt;
  logic jog_r, jog_nxt;
  show_type show_r, show_nxt;

  always_comb begin
    fwd_nxt = 1'b0;
    rev_nxt = 1'b0;
    jog_nxt = 1'b0;
    case (seq_mode)
      MODE_LOGIC_SEQ: begin
        fwd_nxt = seq_nxt[0] && !seq_nxt[2];
        rev_nxt = seq_nxt[0] && seq_nxt[2];
        jog_nxt = seq_nxt[1];
      end
      MODE_WIRE_PROOF: begin
        // Both run bits at once is contradictory, so neither runs
        fwd_nxt = seq_nxt[0] && !seq_nxt[2];
        rev_nxt = seq_nxt[2] && !seq_nxt[0];
        jog_nxt = seq_nxt[1];
      end
      default: begin
        fwd_nxt = 1'b0;
        rev_nxt = 1'b0;
        jog_nxt = 1'b0;
      end
    endcase
    // Disable wins at once; the motor is simply left to coast
    if (!enable_nxt) begin
      fwd_nxt = 1'b0;
      rev_nxt = 1'b0;
      jog_nxt = 1'b0;
    end
    if (!enable_nxt) begin
      show_nxt = SHOW_INHIBIT;
    end else if (rev_nxt) begin
      show_nxt = SHOW_REVERSE;
    end else if (fwd_nxt) begin
      show_nxt = SHOW_FORWARD;
    end else begin
      show_nxt = SHOW_STOPPED;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      jog_r <= 1'b0;
      show_r <= SHOW_INHIBIT;
    end else begin
      fwd_r <= fwd_nxt;
      rev_r <= rev_nxt;
      jog_r <= jog_nxt;
      show_r <= show_nxt;
    end
  end

  // ----------------------------------------
  // Parameter reads
  // ----------------------------------------
  logic [15:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;

  // Command word is write-only in effect: a read answers with status
  always_comb begin
    rdata_nxt = 16'h0000;
    ack_nxt = acc_wr || acc_rd;
    err_nxt = 1'b0;
    if (acc_rd) begin
      if (acc_code == CODE_CMD_WORD) begin
        rdata_nxt = DC_VARIANT ? dc_state_word : state_word;
      end else if (!DC_VARIANT && (acc_code == CODE_STATE_WORD)) begin
        rdata_nxt = state_word;
      end else begin
        err_nxt = 1'b1;
      end
    end else if (acc_wr && !cmd_write) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------
  // Output slot mapping
  // ----------------------------------------
  // Input mappings are not checked for clashes here; that stays with the user
  logic [13:0] map_r [NUM_SLOTS];
  logic [13:0] map_nxt [NUM_SLOTS];
  logic reject_r, reject_nxt;
  logic [16*NUM_SLOTS-1:0] slots_r, slots_nxt;

  always_comb begin
    reject_nxt = 1'b0;
    slots_nxt = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      map_nxt[i] = map_r[i];
    end
    if (map_wr) begin
      if (map_ok(map_value)) begin
        map_nxt[map_slot] = map_value;
      end else begin
        reject_nxt = 1'b1;
      end
    end
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (map_r[i] == CODE_STATE_WORD) begin
        slots_nxt[16*i +: 16] = state_word;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        map_r[i] <= MAP_RESET;
      end
      reject_r <= 1'b0;
      slots_r <= '0;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        map_r[i] <= map_nxt[i];
      end
      reject_r <= reject_nxt;
      slots_r <= slots_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign acc_rdata = rdata_r;
  assign acc_ack = ack_r;
  assign acc_err = err_r;
  assign map_reject = reject_r;
  assign slot_words = slots_r;
  assign drive_enable = enable_r;
  assign seq_bits = seq_r;
  assign preset_sel = preset_r;
  assign app_bits = app_r;
  assign run_fwd = fwd_r;
  assign run_rev = rev_r;
  assign jog = jog_r;
  assign shown_state = show_r;
  assign ext_trip = trip_r;
  assign ext_trip_code = code_r;
endmodule // drive_control_status_words
`default_nettype wire

// *** control_word_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------
// Checker
// ------
module control_word_checker #(
  parameter int NUM_SLOTS = 4,
  parameter bit DC_VARIANT = 1'b0,
  parameter logic [7:0] EXT_TRIP_CODE = drive_word_pkg::EXT_TRIP_CODE_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access port
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [13:0] acc_code,
  input wire logic [15:0] acc_wdata,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_ack,
  // Drive side
  input wire logic [14:0] cond_bits,
  input wire logic drive_enable,
  input wire logic [2:0] app_bits,
  input wire logic run_fwd,
  input wire logic run_rev,
  input wire logic [1:0] shown_state,
  input wire logic ext_trip,
  input wire logic [7:0] ext_trip_code
);
  import drive_word_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr9;
  logic [15:0] wd_d;
  // Command word write strobe
  assign wr9 = acc_wr && acc_code == CODE_CMD_WORD;
  // Last data word, so single fields can be looked back at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wd_d <= 16'h0000;
    else wd_d <= acc_wdata;
  end
  property p_trip; wr9 && acc_wdata[BIT_TRIP] |=> ext_trip; endproperty
  a_trip: assert property (p_trip) else $error("no trip pulse");
  property p_code; ext_trip |-> ext_trip_code == EXT_TRIP_CODE; endproperty
  a_code: assert property (p_code) else $error("bad trip code");
  property p_hold; wr9 && !acc_wdata[BIT_MASK0] |=> $stable(drive_enable); endproperty
  a_hold: assert property (p_hold) else $error("masked enable moved");
  property p_copy; wr9 && acc_wdata[BIT_MASK0] |=> drive_enable == wd_d[BIT_ENABLE]; endproperty
  a_copy: assert property (p_copy) else $error("enable not copied");
  property p_app; wr9 |=> app_bits == {wd_d[BIT_APP2], wd_d[BIT_APP1], wd_d[BIT_APP0]}; endproperty
  a_app: assert property (p_app) else $error("app bits wrong");
  property p_inh; !drive_enable |-> !run_fwd && !run_rev && shown_state == 2'h0; endproperty
  a_inh: assert property (p_inh) else $error("disabled yet running");
  property p_show; drive_enable |-> shown_state == (run_rev ? 2'h3 : run_fwd ? 2'h2 : 2'h1);
  endproperty
  a_show: assert property (p_show) else $error("shown state wrong");
  property p_rd; acc_rd && acc_code == CODE_CMD_WORD && !DC_VARIANT
    |=> acc_ack && acc_rdata == {1'b0, $past(cond_bits, 2)}; endproperty
  a_rd: assert property (p_rd) else $error("read gave no status");
endmodule // control_word_checker
bind drive_control_status_words control_word_checker #(.NUM_SLOTS(NUM_SLOTS),
  .DC_VARIANT(DC_VARIANT), .EXT_TRIP_CODE(EXT_TRIP_CODE)) control_word_checker_i (
  .clk, .rst_n, .acc_wr, .acc_rd, .acc_code, .acc_wdata, .acc_rdata, .acc_ack, .cond_bits,
  .drive_enable, .app_bits, .run_fwd, .run_rev, .shown_state, .ext_trip, .ext_trip_code);
`default_nettype wire

// *** master_node_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------
// Master node
// ------
// Input routing of sequencing bits is taken as switched off
// Polled mappings are kept clear of input mappings
module master_node_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic acc_wr,
  output logic acc_rd,
  output logic [13:0] acc_code,
  output logic [15:0] acc_wdata
);
  logic [15:0] tmp_word;
  // One request, launched after an edge and held over the next one
  task automatic req(input logic w, input logic r, input logic [13:0] c, input logic [15:0] d);
    tmp_word = d; // Word is built aside, then moved out
    acc_wr = w;
    acc_rd = r;
    acc_code = c;
    acc_wdata = tmp_word;
    @(posedge clk);
    #1;
  endtask
  // Released lines flip so a stale value is never mistaken for data
  task automatic idle();
    req(1'b0, 1'b0, ~acc_code, ~acc_wdata);
  endtask
endmodule // master_node_model
`default_nettype wire

// *** drive_control_status_words_test.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------
// Testbench
// ------
module drive_control_status_words_test;
  import drive_word_pkg::*;
  logic clk, rst_n, acc_wr, acc_rd, acc_ack, acc_err, map_wr, map_reject;
  logic drive_enable, run_fwd, run_rev, jog, ext_trip, en;
  logic [13:0] acc_code, map_value;
  logic [15:0] acc_wdata, acc_rdata;
  logic [1:0] map_slot, preset_sel, shown_state, ps;
  logic [63:0] slot_words;
  logic [2:0] seq_mode, seq_bits, app_bits, sq, ap;
  logic [14:0] cond_bits;
  logic [7:0] led_status, trip_code, ext_trip_code;
  logic [31:0] seed, v;
  logic [31:0] q[$];
  int err_total, tests_run, cyc;
  drive_control_status_words #(.NUM_SLOTS(4), .DC_VARIANT(1'b0), .EXT_TRIP_CODE(8'h34))
    drive_control_status_words_i (.clk, .rst_n, .acc_wr, .acc_rd, .acc_code, .acc_wdata,
    .acc_rdata, .acc_ack, .acc_err, .map_wr, .map_slot, .map_value, .map_reject, .slot_words,
    .seq_mode, .cond_bits, .led_status, .trip_code, .drive_enable, .seq_bits, .preset_sel,
    .app_bits, .run_fwd, .run_rev, .jog, .shown_state, .ext_trip, .ext_trip_code);
  master_node_model master_node_model_i (.clk, .acc_wr, .acc_rd, .acc_code, .acc_wdata);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    tests_run = tests_run + 1;
    if (seen !== want) begin
      err_total = err_total + 1;
      $display("unexpected at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Expected answer from the held copy; a disable must clear jog as well
  task automatic note(input logic err, input logic [15:0] rd, input logic trp);
    logic ok, f, r;
    ok = seq_mode == MODE_LOGIC_SEQ || seq_mode == MODE_WIRE_PROOF;
    f = en & ok & sq[0] & ~sq[2];
    r = en & ok & sq[2] & (seq_mode == MODE_LOGIC_SEQ ? sq[0] : ~sq[0]);
    q.push_back({err, rd, en, sq, ps, ap, f, r, en & ok & sq[1],
      !en ? 2'h0 : r ? 2'h3 : f ? 2'h2 : 2'h1, trp});
  endtask
  task automatic put_cmd(input logic [15:0] d, input logic [2:0] m);
    d[1] = d[1] | d[2]; // Jog always sent with run
    seq_mode = m;
    if (d[9]) en = d[0];
    if (d[10]) sq[0] = d[1];
    if (d[11]) sq[1] = d[2];
    if (d[12]) sq[2] = d[3];
    if (d[14]) ps[0] = d[5];
    if (d[15]) ps[1] = d[6];
    ap = {d[13], d[8], d[7]};
    note(1'b0, 16'h0000, d[4]);
    master_node_model_i.req(1'b1, 1'b0, CODE_CMD_WORD, d);
  endtask
  task automatic get(input logic [13:0] c, input logic good);
    note(!good, good ? {1'b0, cond_bits} : 16'h0000, 1'b0);
    master_node_model_i.req(1'b0, 1'b1, c, 16'h0000);
  endtask
  // Each answer is matched against the oldest note
  always @(negedge clk) begin
    if (acc_ack === 1'b1) begin
      if (q.size() == 0) chk(64'h1, 64'h0);
      else chk({acc_err, acc_rdata, drive_enable, seq_bits, preset_sel, app_bits, run_fwd,
        run_rev, jog, shown_state, ext_trip}, q.pop_front());
    end
  end
  // Hang guard, well above the length of the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end
  initial begin
    {seed, err_total, tests_run, cyc} = {32'h72a6, 96'h0};
    {en, sq, ps, ap, rst_n, map_wr, map_slot, map_value} = 27'h0;
    {seq_mode, cond_bits, led_status, trip_code} = 34'h0;
    master_node_model_i.req(1'b0, 1'b0, 14'h0000, 16'h0000);
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 240; i++) begin
      v = rnd();
      if (i % 24 == 0) begin
        {trip_code, led_status, cond_bits} = v[30:0];
        master_node_model_i.idle();
        put_cmd(16'h1e03, MODE_LOGIC_SEQ);
        put_cmd(16'h1e09, MODE_WIRE_PROOF);
        put_cmd(16'h0011, MODE_LOGIC_SEQ);
      end
      case (v[2:0])
        3'h0, 3'h1, 3'h2: put_cmd(v[31:16], v[5] ? v[8:6] : v[4] ? MODE_WIRE_PROOF : MODE_LOGIC_SEQ);
        3'h3: get(CODE_CMD_WORD, 1'b1);
        3'h4: get(CODE_STATE_WORD, 1'b1);
        3'h5: get(14'd100 + v[12:6], 1'b0);
        3'h6: begin
          note(1'b1, 16'h0000, 1'b0);
          master_node_model_i.req(1'b1, 1'b0, CODE_STATE_WORD, v[31:16]);
        end
        default: master_node_model_i.idle();
      endcase
    end
    master_node_model_i.idle();
    // Slots 0 and 3 take the status word; the codes either side must not
    for (int k = 0; k < 4; k++) begin
      map_wr = 1'b1;
      map_slot = k[1:0];
      map_value = k == 1 ? CODE_STATE_WORD - 14'd1 : k == 2 ? CODE_STATE_WORD + 14'd1 : CODE_STATE_WORD;
      @(posedge clk);
      #1;
      chk(map_reject, 64'h0);
    end
    map_wr = 1'b0;
    repeat (3) master_node_model_i.idle();
    chk(slot_words, {1'b0, cond_bits, 32'h0, 1'b0, cond_bits});
    chk(q.size(), 64'h0);
    wrap_up();
  end
endmodule // drive_control_status_words_test
`default_nettype wire
